// >>> src/dsr_regs.sv
// Design decision made here: register access over Wishbone.
`default_nettype none
// Functional notes
// - Drawing registers answer only while config bit 0 is one.
// - Each drawing register takes byte or 16-bit word accesses.
// - Reading the event word gives four pending flags in bits 3-0.
// - Writing the event word clears flags selected by bits 3-0.
// - Control bits 11-8 enable the four events for the request.
// - Control bits 15-14 pick an engine reset, applied on write.
// - Event word bit 7 shows four or eight bit plane organisation.
// - Function word bit 0 turns enhanced drawing mode on or off.
// - Function bits 2, 4, 5 pick 4bpp, linear, memory map access.
// - Current vertical coordinate holds 12 bits, 15-12 reserved.
// - Second vertical coordinate holds 12 bits, 15-12 reserved.
// - Engine status bit 9 is busy and bit 10 is command fifo empty.
module dsr_regs
  import dsr_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // wishbone classic slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [DSR_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [DSR_DAT_W-1:0] wb_dat_i,
  output logic      [DSR_DAT_W-1:0] wb_dat_o,
  output logic                      wb_ack_o,
  // engine events, one cycle pulses
  input  wire logic                 vsync_evt_i,
  input  wire logic                 busy_evt_i,
  input  wire logic                 fifo_ovf_evt_i,
  input  wire logic                 fifo_empty_evt_i,
  // engine levels
  input  wire logic                 engine_busy_i,
  input  wire logic                 fifo_all_empty_i,
  input  wire logic                 eight_planes_i,
  // mode outputs
  output logic                      enh_mode_en_o,
  output logic                      four_bpp_o,
  output logic                      linear_addr_en_o,
  output logic                      mmio_en_o,
  // coordinates for drawing commands
  output logic [DSR_COORD_W-1:0]    cur_y_o,
  output logic [DSR_COORD_W-1:0]    cur_y2_o,
  // engine software reset
  output logic [1:0]                eng_rst_sel_o,
  output logic                      eng_rst_stb_o,
  // interrupt request
  output logic                      irq_o
);

  // ==========================================================
  // state
  // bus answer, read data and every software visible field sit
  // in one record, so reset and the next-state copy stay in step
  // the pending flags live in the flag block, not here, so the
  // set-over-clear priority is kept in one place
  typedef struct packed {
    dsr_bus_st_t            bus;
    logic [DSR_DAT_W-1:0]   dat;
    logic                   syscfg;
    logic [3:0]             en;
    logic [1:0]             rst_sel;
    logic                   rst_stb;
    logic [15:0]            afc;
    logic [DSR_COORD_W-1:0] cur_y;
    logic [DSR_COORD_W-1:0] cur_y2;
  } dsr_state_t;

  dsr_state_t s_q;
  dsr_state_t s_d;

  dsr_evt_if evt_bus ();

  logic [DSR_IDX_W-1:0] idx;
  logic                 take;
  logic                 wr;
  logic                 enh;
  logic                 hit_cfg;
  logic                 hit_evt;
  logic                 hit_afc;
  logic                 hit_cury;
  logic                 hit_cury2;
  logic                 hit_engst;
  logic [15:0]          rdata;
  logic [15:0]          wmerge_afc;
  logic [15:0]          wmerge_y;
  logic [15:0]          wmerge_y2;
  logic [3:0]           clr;

  // ==========================================================
  // merge a byte or word write into a 16-bit register
  function automatic logic [15:0] dsr_merge(
    input logic [15:0] old_v,
    input logic [15:0] new_v,
    input logic [1:0]  sel
  );
    logic [15:0] r;
    r = old_v;
    if (sel[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (sel[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction

  // ==========================================================
  // address decode
  // a request is taken only from idle, so each one is answered once
  // a strobe still high in the ack cycle is ignored, and the master
  // must drop it before the slave is idle again or it is taken twice
  // the index drops the two byte address bits, so the sixteen bit
  // register number compares directly with the package constants
  assign take = wb_cyc_i & wb_stb_i & (s_q.bus == DSR_BUS_IDLE);
  assign wr   = take & wb_we_i;
  assign idx  = wb_adr_i[DSR_ADR_W-1:2];
  assign enh  = s_q.syscfg;

  // the config word itself is always decoded, else it could
  // never be switched back on
  assign hit_cfg   = (idx == DSR_IDX_SYSCFG);
  assign hit_evt   = enh & (idx == DSR_IDX_EVT);
  assign hit_afc   = enh & (idx == DSR_IDX_AFC);
  assign hit_cury  = enh & (idx == DSR_IDX_CURY);
  assign hit_cury2 = enh & (idx == DSR_IDX_CURY2);
  assign hit_engst = enh & (idx == DSR_IDX_ENGST);

  // ==========================================================
  // write data merge
  // reserved bits of the coordinate words are never stored, so the
  // merge starts from zero there and they always read back as zero
  // byte or word lanes
  assign wmerge_afc = dsr_merge(s_q.afc, wb_dat_i[15:0],
                                wb_sel_i[1:0]);
  assign wmerge_y   = dsr_merge({4'h0, s_q.cur_y}, wb_dat_i[15:0],
                                wb_sel_i[1:0]);
  assign wmerge_y2  = dsr_merge({4'h0, s_q.cur_y2}, wb_dat_i[15:0],
                                wb_sel_i[1:0]);

  // ==========================================================
  // flag clears, low byte lane of the control word
  // a clear is a single cycle pulse at the taking edge; an event
  // pulse in the same cycle still sets its flag, so none is lost
  // a write without the low lane never clears anything
  // write ones to clear
  assign clr = (wr & hit_evt & wb_sel_i[0])
             ? wb_dat_i[DSR_EVT_CLR_LSB +: 4] : 4'h0;

  assign evt_bus.clr = clr;
  assign evt_bus.en  = s_q.en;

  // ==========================================================
  // read mux, reserved bits read zero
  // the mux is sampled only at the taking edge, into the answer
  // register, so level inputs need no synchroniser of their own
  // while they are steady around that edge
  // gated drawing addresses fall through to the zero default
  always_comb begin
    rdata = 16'h0000;
    if (hit_cfg) begin
      rdata[DSR_SYSCFG_ENH_BIT] = s_q.syscfg;
    end else if (hit_evt) begin
      rdata[DSR_EVT_CLR_LSB +: 4] = evt_bus.pend;
      rdata[DSR_EVT_PLANES_BIT] = eight_planes_i;
    end else if (hit_afc) begin
      rdata = s_q.afc;
    end else if (hit_cury) begin
      rdata[DSR_COORD_W-1:0] = s_q.cur_y;
    end else if (hit_cury2) begin
      rdata[DSR_COORD_W-1:0] = s_q.cur_y2;
    end else if (hit_engst) begin
      rdata[DSR_ENGST_BUSY_BIT]  = engine_busy_i;
      rdata[DSR_ENGST_EMPTY_BIT] = fifo_all_empty_i;
    end
  end

  // ==========================================================
  // next state
  // the answer takes exactly one cycle; the ack state always returns
  // to idle, so a stuck master cannot hold the slave busy
  // register writes use the same taking edge as the answer, so a
  // read right after a write always sees the new value
  always_comb begin
    s_d         = s_q;
    s_d.rst_stb = 1'b0;
    case (s_q.bus)
      DSR_BUS_IDLE: begin
        if (take) begin
          s_d.bus = DSR_BUS_ACK;
          // unmapped or gated reads answer with zero
          s_d.dat = wb_we_i ? '0 : {16'h0000, rdata};
        end
      end
      DSR_BUS_ACK: begin
        // ack stands one cycle, then the slave idles again
        s_d.bus = DSR_BUS_IDLE;
        s_d.dat = '0;
      end
      default: begin
        s_d.bus = DSR_BUS_IDLE;
      end
    endcase

    if (wr && hit_cfg && wb_sel_i[0]) begin
      s_d.syscfg = wb_dat_i[DSR_SYSCFG_ENH_BIT];
    end

    // high byte of the control word: enables and reset select
    if (wr && hit_evt && wb_sel_i[1]) begin
      s_d.en      = wb_dat_i[DSR_EVT_EN_LSB +: 4];
      s_d.rst_sel = wb_dat_i[DSR_EVT_RST_LSB +: 2];
      s_d.rst_stb = 1'b1;
    end

    if (wr && hit_afc) begin
      s_d.afc = wmerge_afc;
    end

    if (wr && hit_cury) begin
      s_d.cur_y = wmerge_y[DSR_COORD_W-1:0];
    end

    if (wr && hit_cury2) begin
      s_d.cur_y2 = wmerge_y2[DSR_COORD_W-1:0];
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q.bus     <= DSR_BUS_IDLE;
      s_q.dat     <= '0;
      s_q.syscfg  <= DSR_SYSCFG_RST;
      s_q.en      <= DSR_EN_RST;
      s_q.rst_sel <= DSR_RSTSEL_RST;
      s_q.rst_stb <= 1'b0;
      s_q.afc     <= DSR_AFC_RST;
      s_q.cur_y   <= DSR_COORD_RST;
      s_q.cur_y2  <= DSR_COORD_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // event flags
  // event inputs are ordered vsync, busy, overflow, empty from bit 0
  // up, matching the clear and enable bit order of the control word
  dsr_evt_flags u_flags (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .evt_i ({fifo_empty_evt_i, fifo_ovf_evt_i,
             busy_evt_i, vsync_evt_i}),
    .evt   (evt_bus.flg)
  );

  // ==========================================================
  // outputs
  // every output below comes straight from a register, except the ack,
  // a decode of the registered bus state, and the request, a gate of
  // registered flags and enables; neither carries an extra cycle of delay
  assign wb_ack_o = (s_q.bus == DSR_BUS_ACK);
  assign wb_dat_o = s_q.dat;

  assign enh_mode_en_o    = s_q.afc[DSR_AFC_ENH_BIT];
  assign four_bpp_o       = s_q.afc[DSR_AFC_4BPP_BIT];
  assign linear_addr_en_o = s_q.afc[DSR_AFC_LIN_BIT];
  assign mmio_en_o        = s_q.afc[DSR_AFC_MMIO_BIT];

  assign cur_y_o  = s_q.cur_y;
  assign cur_y2_o = s_q.cur_y2;

  // the engine applies the selection on the strobe only
  // the strobe fires on every high byte write, even with an unchanged
  // selection, so software can repeat a reset without toggling it
  assign eng_rst_sel_o = s_q.rst_sel;
  assign eng_rst_stb_o = s_q.rst_stb;

  assign irq_o = evt_bus.irq;

endmodule
`default_nettype wire

// >>> src/dsr_pkg.sv
`default_nettype none
// ============================================================
// shared constants of the drawing engine subsystem registers
package dsr_pkg;

  // ==========================================================
  // widths
  localparam int unsigned DSR_NUM_EVT = 4;
  localparam int unsigned DSR_ADR_W   = 18;
  localparam int unsigned DSR_DAT_W   = 32;
  localparam int unsigned DSR_IDX_W   = 16;
  localparam int unsigned DSR_COORD_W = 12;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [15:0] DSR_IDX_SYSCFG = 16'h0040;
  localparam logic [15:0] DSR_IDX_EVT    = 16'h42e8;
  localparam logic [15:0] DSR_IDX_AFC    = 16'h4ae8;
  localparam logic [15:0] DSR_IDX_CURY   = 16'h82e8;
  localparam logic [15:0] DSR_IDX_CURY2  = 16'h82ea;
  localparam logic [15:0] DSR_IDX_ENGST  = 16'h9ae8;

  // ==========================================================
  // field positions
  localparam int unsigned DSR_SYSCFG_ENH_BIT = 0;
  localparam int unsigned DSR_EVT_CLR_LSB    = 0;
  localparam int unsigned DSR_EVT_PLANES_BIT = 7;
  localparam int unsigned DSR_EVT_EN_LSB     = 8;
  localparam int unsigned DSR_EVT_RST_LSB    = 14;
  localparam int unsigned DSR_AFC_ENH_BIT    = 0;
  localparam int unsigned DSR_AFC_4BPP_BIT   = 2;
  localparam int unsigned DSR_AFC_LIN_BIT    = 4;
  localparam int unsigned DSR_AFC_MMIO_BIT   = 5;
  localparam int unsigned DSR_ENGST_BUSY_BIT = 9;
  localparam int unsigned DSR_ENGST_EMPTY_BIT = 10;

  // ==========================================================
  // reset values
  localparam logic        DSR_SYSCFG_RST = 1'b0;
  localparam logic [3:0]  DSR_EN_RST     = 4'h0;
  localparam logic [1:0]  DSR_RSTSEL_RST = 2'h0;
  localparam logic [15:0] DSR_AFC_RST    = 16'h0000;
  localparam logic [11:0] DSR_COORD_RST  = 12'h000;
  localparam logic [3:0]  DSR_PEND_RST   = 4'h0;

  // ==========================================================
  // bus answer states, gray coded
  typedef enum logic [1:0] {
    DSR_BUS_IDLE = 2'b00,
    DSR_BUS_ACK  = 2'b01
  } dsr_bus_st_t;

endpackage
`default_nettype wire

// >>> src/dsr_evt_if.sv
`default_nettype none
// ============================================================
// event flag carrier between register file and flag block
interface dsr_evt_if;
  logic [3:0] clr;
  logic [3:0] en;
  logic [3:0] pend;
  logic       irq;

  modport ctl (output clr, output en, input pend, input irq);
  modport flg (input clr, input en, output pend, output irq);
endinterface
`default_nettype wire

// >>> src/dsr_evt_flags.sv
`default_nettype none
// ============================================================
// four sticky event flags with enable gating
module dsr_evt_flags
  import dsr_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // event pulses from the engine
  input  wire logic [3:0] evt_i,
  // register file side
  dsr_evt_if.flg          evt
);

  typedef struct packed {
    logic [3:0] pend;
  } dsr_flg_state_t;

  dsr_flg_state_t s_q;
  dsr_flg_state_t s_d;
  logic [3:0]     pend_nxt;

  // ==========================================================
  // per flag: set beats clear so no event is lost
  for (genvar g = 0; g < DSR_NUM_EVT; g++) begin : g_flag
    assign pend_nxt[g] = evt_i[g] | (s_q.pend[g] & ~evt.clr[g]);
  end

  // next state copy
  always_comb begin
    s_d      = s_q;
    s_d.pend = pend_nxt;
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q.pend <= DSR_PEND_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign evt.pend = s_q.pend;
  assign evt.irq  = |(s_q.pend & evt.en);

endmodule
`default_nettype wire

// >>> bench/dsr_regs_assertions.sv
`default_nettype none
// ==========================================================
// port level checks of the subsystem register block
module dsr_regs_assertions
  import dsr_pkg::*;
(
  // clock and reset
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  // bus
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [DSR_ADR_W-1:0]   wb_adr_i,
  input wire logic [3:0]             wb_sel_i,
  input wire logic [DSR_DAT_W-1:0]   wb_dat_i,
  input wire logic [DSR_DAT_W-1:0]   wb_dat_o,
  input wire logic                   wb_ack_o,
  // engine levels
  input wire logic                   engine_busy_i,
  input wire logic                   fifo_all_empty_i,
  input wire logic                   eight_planes_i,
  // observed outputs
  input wire logic                   enh_mode_en_o,
  input wire logic                   four_bpp_o,
  input wire logic [DSR_COORD_W-1:0] cur_y_o,
  input wire logic [DSR_COORD_W-1:0] cur_y2_o,
  input wire logic [1:0]             eng_rst_sel_o,
  input wire logic                   eng_rst_stb_o,
  input wire logic                   irq_o
);
  logic        tk;
  logic        wr;
  logic        cfg_q;
  logic [15:0] ix;
  // a request counts only while the slave is idle
  assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = tk && wb_we_i;
  assign ix = wb_adr_i[17:2];
  // shadow of the decode enable, so checks know what should answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= 1'b0;
    end else if (wr && ix == DSR_IDX_SYSCFG && wb_sel_i[0]) begin
      cfg_q <= wb_dat_i[0];
    end
  end
  // every operand is an argument, so the check sees sampled values
  function automatic logic at(logic c, logic [15:0] a, logic [15:0] i);
    return c && a == i;
  endfunction
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_one_shot: assert property (tk |=> s_ack)
    else $error("ack is not one cycle after the request");
  a_no_decode: assert property (
    tk && !wb_we_i && !cfg_q && ix != DSR_IDX_SYSCFG |=> wb_dat_o == '0)
    else $error("drawing register answered while disabled");
  a_status_bits: assert property (
    tk && !wb_we_i && at(cfg_q, ix, DSR_IDX_EVT) |=>
      wb_dat_o[31:4] == {24'h0, $past(eight_planes_i), 3'h0})
    else $error("event status upper bits wrong");
  a_engine_bits: assert property (
    tk && !wb_we_i && at(cfg_q, ix, DSR_IDX_ENGST) |=> wb_dat_o ==
      {21'h0, $past(fifo_all_empty_i), $past(engine_busy_i), 9'h0})
    else $error("engine status bits wrong");
  a_reset_sel: assert property (
    wr && at(cfg_q, ix, DSR_IDX_EVT) && wb_sel_i[1] |=>
      eng_rst_stb_o && eng_rst_sel_o == $past(wb_dat_i[15:14]))
    else $error("engine reset not applied on write");
  a_strobe_cause: assert property (
    eng_rst_stb_o |->
      $past(wr && at(cfg_q, ix, DSR_IDX_EVT) && wb_sel_i[1]))
    else $error("engine reset strobe without write");
  a_mode_write: assert property (
    wr && at(cfg_q, ix, DSR_IDX_AFC) && wb_sel_i[0] |=>
      {four_bpp_o, enh_mode_en_o} ==
        {$past(wb_dat_i[2]), $past(wb_dat_i[0])})
    else $error("mode outputs do not follow the function word");
  a_mode_hold: assert property (
    !(wr && ix == DSR_IDX_AFC) |=> $stable({four_bpp_o, enh_mode_en_o}))
    else $error("mode outputs changed without a write");
  a_coord_one: assert property (
    wr && at(cfg_q, ix, DSR_IDX_CURY) && wb_sel_i[1:0] == 2'h3 |=>
      cur_y_o == $past(wb_dat_i[11:0]))
    else $error("first coordinate not stored");
  a_coord_two: assert property (
    wr && at(cfg_q, ix, DSR_IDX_CURY2) && wb_sel_i[1:0] == 2'h3 |=>
      cur_y2_o == $past(wb_dat_i[11:0]))
    else $error("second coordinate not stored");
  a_irq_drop: assert property (
    $fell(irq_o) && !$past(rst_i) |-> $past(wr))
    else $error("request dropped without a write");
endmodule

bind dsr_regs dsr_regs_assertions u_dsr_regs_assertions (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .engine_busy_i(engine_busy_i), .fifo_all_empty_i(fifo_all_empty_i),
  .eight_planes_i(eight_planes_i), .enh_mode_en_o(enh_mode_en_o),
  .four_bpp_o(four_bpp_o), .cur_y_o(cur_y_o), .cur_y2_o(cur_y2_o),
  .eng_rst_sel_o(eng_rst_sel_o), .eng_rst_stb_o(eng_rst_stb_o),
  .irq_o(irq_o)
);
`default_nettype wire

// >>> bench/dsr_host.sv
`default_nettype none
// ==========================================================
// host processor model, classic wishbone master
module dsr_host
  import dsr_pkg::*;
(
  // clock
  input  wire logic                 clk_i,
  // wishbone classic master
  output logic                      wb_cyc_o,
  output logic                      wb_stb_o,
  output logic                      wb_we_o,
  output logic      [DSR_ADR_W-1:0] wb_adr_o,
  output logic      [3:0]           wb_sel_o,
  output logic      [DSR_DAT_W-1:0] wb_dat_o,
  input  wire logic [DSR_DAT_W-1:0] wb_dat_i,
  input  wire logic                 wb_ack_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
  end
  // gap idles the bus first, acting as a slow host
  // byte or word lanes
  task automatic xfer(input logic we, input logic [17:0] adr,
      input logic [3:0] sel, input logic [31:0] dat, input int gap,
      output logic [31:0] rdat, output logic ok);
    ok = 1'b0;
    rdat = '0;
    repeat (gap + 1) @(posedge clk_i);
    {wb_cyc_o, wb_stb_o, wb_we_o} <= {2'h3, we};
    {wb_adr_o, wb_sel_o, wb_dat_o} <= {adr, sel, dat};
    for (int n = 0; n < 32 && !ok; n++) begin
      @(posedge clk_i);
      if (wb_ack_i === 1'b1) begin
        ok = 1'b1;
        rdat = wb_dat_i;
        {wb_cyc_o, wb_stb_o} <= 2'h0;
        // released lines must not keep looking valid
        {wb_adr_o, wb_dat_o} <= {~adr, ~dat};
      end
    end
  endtask
endmodule
`default_nettype wire

// >>> bench/dsr_regs_bench.sv
`default_nettype none
// ==========================================================
// self checking bench of the subsystem register block
module dsr_regs_bench
  import dsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, cyc, stb, we, ack, busy, empty, planes;
  logic        enh, bpp4, lin, mmio, rstb, irq;
  logic [17:0] adr;
  logic [3:0]  sel, ev;
  logic [31:0] wdat, rdat;
  logic [11:0] cy, cy2;
  logic [1:0]  rsel;
  int          errors, tests_run, slow;
  dsr_regs u_dsr_regs (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .vsync_evt_i(ev[0]),
    .busy_evt_i(ev[1]), .fifo_ovf_evt_i(ev[2]), .fifo_empty_evt_i(ev[3]),
    .engine_busy_i(busy), .fifo_all_empty_i(empty),
    .eight_planes_i(planes), .enh_mode_en_o(enh), .four_bpp_o(bpp4),
    .linear_addr_en_o(lin), .mmio_en_o(mmio), .cur_y_o(cy),
    .cur_y2_o(cy2), .eng_rst_sel_o(rsel), .eng_rst_stb_o(rstb),
    .irq_o(irq));
  dsr_host u_dsr_host (
    .clk_i(clk), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat), .wb_dat_i(rdat),
    .wb_ack_i(ack));
  // ==========================================================
  // helpers
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] ix,
      input logic [3:0] s, input logic [15:0] d, output logic [31:0] r);
    logic ok;
    u_dsr_host.xfer(w, {ix, 2'b00}, s, {16'h0, d}, slow, r, ok);
    chk("ack", 32'h1, {31'h0, ok});
    if (!ok) begin
      end_of_test();
    end
    @(negedge clk);
  endtask
  task automatic wr(input logic [15:0] ix, input logic [3:0] s,
      input logic [15:0] d);
    logic [31:0] r;
    bus(1'b1, ix, s, d, r);
  endtask
  task automatic rdc(input string what, input logic [15:0] ix,
      input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, ix, 4'h3, 16'h0, r);
    chk(what, exp, r);
  endtask
  // one cycle event pulse, outputs checked at the falling edge after
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 4'h0;
    @(negedge clk);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_decode();
    chk("idle outputs", 32'h0, {enh, bpp4, lin, mmio, irq, rsel, cy});
    wr(DSR_IDX_CURY, 4'h3, 16'h0123);
    rdc("cury off", DSR_IDX_CURY, 32'h0);
    chk("cury pin off", 32'h0, {20'h0, cy});
    wr(DSR_IDX_SYSCFG, 4'h1, 16'h0001);
    rdc("config", DSR_IDX_SYSCFG, 32'h1);
    rdc("cury on", DSR_IDX_CURY, 32'h0);
    $display("test decode done");
  endtask
  task automatic t_events();
    wr(DSR_IDX_EVT, 4'h2, 16'h0f00);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      planes <= i[0];
      pulse(4'h1 << i);
      chk("irq set", 32'h1, {31'h0, irq});
      rdc("status", DSR_IDX_EVT, {24'h0, i[0], 3'h0, 4'h1 << i});
      wr(DSR_IDX_EVT, 4'h1, 16'h1 << i);
      chk("irq clear", 32'h0, {31'h0, irq});
      rdc("status clear", DSR_IDX_EVT, {24'h0, i[0], 7'h0});
    end
    $display("test events done");
  endtask
  task automatic t_mask();
    wr(DSR_IDX_EVT, 4'h2, 16'h0000);
    pulse(4'h1);
    chk("irq masked", 32'h0, {31'h0, irq});
    rdc("flag kept", DSR_IDX_EVT, {24'h0, planes, 7'h1});
    wr(DSR_IDX_EVT, 4'h2, 16'h0100);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(DSR_IDX_EVT, 4'h3, 16'h0101);
    chk("irq cleared", 32'h0, {31'h0, irq});
    for (int s = 0; s < 4; s++) begin
      wr(DSR_IDX_EVT, 4'h2, {s[1:0], 14'h0});
      chk("reset select", s, {30'h0, rsel});
    end
    $display("test mask done");
  endtask
  task automatic t_func();
    wr(DSR_IDX_AFC, 4'h3, 16'h0035);
    chk("modes", 32'hf, {28'h0, mmio, lin, bpp4, enh});
    wr(DSR_IDX_AFC, 4'h2, 16'hab00);
    rdc("function hi", DSR_IDX_AFC, 32'hab35);
    wr(DSR_IDX_AFC, 4'h1, 16'h0004);
    chk("modes 4bpp", 32'h2, {28'h0, mmio, lin, bpp4, enh});
    rdc("function lo", DSR_IDX_AFC, 32'hab04);
    $display("test function done");
  endtask
  task automatic t_coord();
    slow = 2;
    wr(DSR_IDX_CURY, 4'h3, 16'hfabc);
    rdc("cury", DSR_IDX_CURY, 32'habc);
    wr(DSR_IDX_CURY2, 4'h1, 16'h5634);
    wr(DSR_IDX_CURY2, 4'h2, 16'h5600);
    rdc("cury2", DSR_IDX_CURY2, 32'h634);
    chk("cury pins", 32'habc634, {8'h0, cy, cy2});
    @(posedge clk);
    {busy, empty} <= 2'b10;
    rdc("engine busy", DSR_IDX_ENGST, 32'h200);
    @(posedge clk);
    {busy, empty} <= 2'b01;
    rdc("engine empty", DSR_IDX_ENGST, 32'h400);
    rdc("unmapped", 16'h3fff, 32'h0);
    wr(DSR_IDX_SYSCFG, 4'h1, 16'h0000);
    rdc("cury gated", DSR_IDX_CURY, 32'h0);
    chk("cury pin kept", 32'habc, {20'h0, cy});
    $display("test coordinate done");
  endtask
  // ==========================================================
  // clock and main sequence
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {errors, tests_run, slow} = '0;
    {rst, ev, busy, empty, planes} = 8'h80;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_decode();
    t_events();
    t_mask();
    t_func();
    t_coord();
    end_of_test();
  end
endmodule
`default_nettype wire
